// File: hw/external_bus_unit.sv
// external bus controller: arbiter, access sequencer, strobes and ahb registers
`timescale 1ns/1ps
module external_bus_unit
   import ext_bus_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // internal masters
   input wire mreq_t cpu_in,
   input wire mreq_t dtc_in,
   output logic cpu_ack,
   output logic dtc_ack,
   output logic [7:0] rdata,
   // external bus pins
   output logic [15:0] ext_addr,
   output logic [7:0] ext_data_out,
   output logic ext_data_oe,
   input wire logic [7:0] ext_data_in,
   output logic addr_strobe_n,
   output logic rd_n,
   output logic wr_n,
   input wire logic wait_n
);
   typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_T1, ST_T2, ST_TW, ST_T3, ST_BURST, ST_END}
      state_t;

   // registers and config decode
   logic [7:0] bus_control_r, bus_control_nxt;
   logic [7:0] sys_ctrl_r, sys_ctrl_nxt;
   logic [7:0] wait_cfg_r, wait_cfg_nxt;
   logic idle_ins, burst_mode, burst_two, burst_long, io_en, ast, pin_en;
   logic [1:0] io_range, prog_waits;
   logic [3:0] burst_max;
   assign idle_ins = bus_control_r[IDLE_INSERT_BIT];
   assign burst_mode = bus_control_r[BURST_ROM_BIT];
   assign burst_two = bus_control_r[BURST_STATE_BIT];
   assign burst_long = bus_control_r[BURST_WORD_BIT];
   assign io_range = bus_control_r[IO_RANGE_HI:IO_RANGE_LO];
   assign io_en = sys_ctrl_r[IO_STROBE_EN_BIT];
   assign ast = wait_cfg_r[ACCESS_STATE_BIT];
   // wait mode: bit hi enables the pin, mode "off" suppresses program waits
   assign pin_en = wait_cfg_r[WAIT_MODE_HI];
   assign prog_waits = (wait_cfg_r[WAIT_MODE_HI:WAIT_MODE_LO] == WAIT_MODE_OFF) ? 2'h0 :
                       wait_cfg_r[WAIT_CNT_HI:WAIT_CNT_LO];
   assign burst_max = burst_long ? BURST_WORDS_LONG : BURST_WORDS_SHORT;

   // wait pin synchroniser; the first stage feeds only the second
   // the data bus is not synchronised: it answers our own strobes and is taken in the
   // last strobe state, whereas two stages would return the word from before the address
   logic wait_m_r, wait_s_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_m_r <= 1'b0;
         wait_s_r <= 1'b0;
      end else begin
         wait_m_r <= ~wait_n;
         wait_s_r <= wait_m_r;
      end
   end

   // arbitration
   logic grant_cpu, grant_dtc, lock;
   mreq_t cur;
   state_t state_r, state_nxt;
   assign cur = grant_dtc ? dtc_in : (grant_cpu ? cpu_in : '0);
   // hold the owner for the whole access and for as long as it keeps requesting
   assign lock = (state_r != ST_IDLE) | cur.req;

   bus_arbiter u_arb (
      .hclk(hclk),
      .hresetn(hresetn),
      .cpu_req(cpu_in.req),
      .dtc_req(dtc_in.req),
      .lock(lock),
      .grant_cpu(grant_cpu),
      .grant_dtc(grant_dtc)
   );

   // access sequencer state
   logic [1:0] wcnt_r, wcnt_nxt;
   logic [3:0] bcnt_r, bcnt_nxt;
   logic burst_r, burst_nxt, bphase_r, bphase_nxt, last_read_r, last_read_nxt;
   logic owner_r, owner_nxt, write_r, write_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [7:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic start, burst_cont, active, io_hit;
   assign start = cur.req;
   assign burst_cont = burst_r && !cur.write && (cur.addr == addr_r + 16'h0001) &&
                       (bcnt_r < burst_max);

   // next-state logic for the external access
   always_comb begin
      state_nxt = state_r;
      wcnt_nxt = wcnt_r;
      bcnt_nxt = bcnt_r;
      burst_nxt = burst_r;
      bphase_nxt = bphase_r;
      last_read_nxt = last_read_r;
      owner_nxt = owner_r;
      write_nxt = write_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      case (state_r)
         ST_IDLE: begin
            if (start) begin
               owner_nxt = grant_dtc;
               write_nxt = cur.write;
               addr_nxt = cur.addr;
               wdata_nxt = cur.wdata;
               if (burst_mode && burst_cont) begin
                  state_nxt = ST_BURST;
                  bphase_nxt = 1'b0;
                  bcnt_nxt = bcnt_r + 4'h1;
               end else begin
                  bcnt_nxt = 4'h1;
                  burst_nxt = 1'b0;
                  if (cur.write && last_read_r && idle_ins) begin
                     state_nxt = ST_GAP;
                  end else begin
                     state_nxt = ST_T1;
                  end
               end
            end else begin
               // a quiet cycle ends both the burst run and the read-to-write hazard
               burst_nxt = 1'b0;
               last_read_nxt = 1'b0;
            end
         end
         ST_GAP: state_nxt = ST_T1;
         ST_T1: state_nxt = ST_T2;
         ST_T2: begin
            if (burst_mode) begin
               state_nxt = ST_T3;
            end else if (!ast) begin
               state_nxt = ST_END;
               rdata_nxt = ext_data_in;
            end else if (prog_waits != 2'h0) begin
               state_nxt = ST_TW;
               wcnt_nxt = prog_waits - 2'h1;
            end else if (pin_en && wait_s_r) begin
               state_nxt = ST_TW;
               wcnt_nxt = 2'h0;
            end else begin
               state_nxt = ST_T3;
            end
         end
         ST_TW: begin
            if (wcnt_r != 2'h0) begin
               wcnt_nxt = wcnt_r - 2'h1;
            end else if (!(pin_en && wait_s_r)) begin
               state_nxt = ST_T3;
            end
         end
         ST_T3: begin
            state_nxt = ST_END;
            rdata_nxt = ext_data_in;
         end
         ST_BURST: begin
            if (burst_two && !bphase_r) begin
               bphase_nxt = 1'b1;
            end else begin
               state_nxt = ST_END;
               rdata_nxt = ext_data_in;
            end
         end
         ST_END: begin
            state_nxt = ST_IDLE;
            last_read_nxt = !write_r;
            burst_nxt = burst_mode && !write_r;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_IDLE;
         wcnt_r <= 2'h0;
         bcnt_r <= 4'h0;
         burst_r <= 1'b0;
         bphase_r <= 1'b0;
         last_read_r <= 1'b0;
         owner_r <= 1'b0;
         write_r <= 1'b0;
         addr_r <= 16'h0000;
         wdata_r <= 8'h00;
         rdata_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         wcnt_r <= wcnt_nxt;
         bcnt_r <= bcnt_nxt;
         burst_r <= burst_nxt;
         bphase_r <= bphase_nxt;
         last_read_r <= last_read_nxt;
         owner_r <= owner_nxt;
         write_r <= write_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // strobes and data drive, all decoded from registered state
   assign active = (state_r == ST_T1) || (state_r == ST_T2) || (state_r == ST_TW) ||
                   (state_r == ST_T3) || (state_r == ST_BURST);
   assign io_hit = (addr_r[15:10] == IO_PAGE_TOP) && (addr_r[9:8] == io_range);
   assign addr_strobe_n = io_en ? !(active && io_hit) : !active;
   assign rd_n = !(active && !write_r);
   assign wr_n = !(active && write_r && (state_r != ST_T1));
   assign ext_data_oe = active && write_r;
   assign ext_addr = addr_r;
   assign ext_data_out = wdata_r;
   assign rdata = rdata_r;
   assign cpu_ack = (state_r == ST_END) && !owner_r;
   assign dtc_ack = (state_r == ST_END) && owner_r;

   // ahb-lite slave: writes complete with no wait, reads insert one wait for a registered hrdata
   logic wr_pend_r, wr_pend_nxt, rd_pend_r, rd_pend_nxt;
   logic [7:0] wr_addr_r, wr_addr_nxt, rd_addr_r, rd_addr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic take;
   assign take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);

   always_comb begin
      wr_pend_nxt = take && hwrite;
      rd_pend_nxt = take && !hwrite;
      wr_addr_nxt = take ? haddr[7:0] : wr_addr_r;
      rd_addr_nxt = take ? haddr[7:0] : rd_addr_r;
      hrdata_nxt = hrdata_r;
      bus_control_nxt = bus_control_r;
      sys_ctrl_nxt = sys_ctrl_r;
      wait_cfg_nxt = wait_cfg_r;
      if (wr_pend_r) begin
         case (wr_addr_r)
            REG_BUS_CONTROL: bus_control_nxt = hwdata[7:0];
            REG_SYS_CTRL: sys_ctrl_nxt = hwdata[7:0];
            REG_WAIT_CFG: wait_cfg_nxt = hwdata[7:0];
            default: bus_control_nxt = bus_control_r;
         endcase
      end
      if (rd_pend_r) begin
         case (rd_addr_r)
            REG_BUS_CONTROL: hrdata_nxt = {24'h000000, bus_control_r};
            REG_SYS_CTRL: hrdata_nxt = {24'h000000, sys_ctrl_r};
            REG_WAIT_CFG: hrdata_nxt = {24'h000000, wait_cfg_r};
            REG_STATUS: begin
               hrdata_nxt = 32'h00000000;
               hrdata_nxt[ST_BUSY_BIT] = (state_r != ST_IDLE);
               hrdata_nxt[ST_OWNER_BIT] = owner_r;
               hrdata_nxt[ST_BURST_BIT] = burst_r;
               hrdata_nxt[ST_WAIT_BIT] = wait_s_r;
            end
            default: hrdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rd_addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
         bus_control_r <= BUS_CONTROL_RST;
         sys_ctrl_r <= SYS_CTRL_RST;
         wait_cfg_r <= WAIT_CFG_RST;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         rd_pend_r <= rd_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         rd_addr_r <= rd_addr_nxt;
         hrdata_r <= hrdata_nxt;
         bus_control_r <= bus_control_nxt;
         sys_ctrl_r <= sys_ctrl_nxt;
         wait_cfg_r <= wait_cfg_nxt;
      end
   end

   assign hreadyout = !rd_pend_r;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // checks beside the logic
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   arb_one_owner_a: assert property (!(grant_cpu && grant_dtc))
      else $error("both masters granted");
   grant_stays_a: assert property (active |=> $stable({grant_cpu, grant_dtc}))
      else $error("grant changed during an access");
   two_state_a: assert property ((state_r == ST_T1 && !burst_mode && !ast)
      |=> state_r == ST_T2 ##1 state_r == ST_END)
      else $error("two-state access not two states");
   prog_wait_a: assert property ((state_r == ST_T2 && !burst_mode && ast &&
      prog_waits == 2'h3 && $stable(wait_cfg_r)) |=> (state_r == ST_TW)[*3])
      else $error("program waits not inserted");
   strobe_mode_a: assert property ((active && !io_en) |-> !addr_strobe_n)
      else $error("address strobe missing");
   io_window_a: assert property ((active && io_en && !io_hit) |-> addr_strobe_n)
      else $error("io select outside window");
   read_strobe_a: assert property ((active && !write_r) |-> (!rd_n && wr_n))
      else $error("read strobe wrong");
   write_strobe_a: assert property ((state_r == ST_T2 && write_r)
      |-> (!wr_n && ext_data_oe && rd_n))
      else $error("write strobe or data drive wrong");
   wait_three_a: assert property ((state_r == ST_TW) |-> (ast && !burst_mode))
      else $error("wait honoured outside three-state");
   idle_gap_a: assert property ((state_r == ST_IDLE && start && cur.write &&
      last_read_r && idle_ins && !(burst_mode && burst_cont))
      |=> state_r == ST_GAP ##1 state_r == ST_T1)
      else $error("idle state not inserted");
   burst_len_a: assert property ((state_r == ST_BURST && !bphase_r && burst_two)
      |=> state_r == ST_BURST ##1 state_r == ST_END)
      else $error("burst cycle length wrong");
   burst_cnt_a: assert property ((state_r == ST_BURST) |-> (bcnt_r <= burst_max))
      else $error("burst longer than limit");
   burst_fixed_a: assert property ((state_r == ST_T2 && burst_mode)
      |=> state_r == ST_T3 ##1 state_r == ST_END)
      else $error("burst first access not fixed length");
   burst_sel_a: assert property ((state_r == ST_BURST) |-> $past(burst_mode))
      else $error("burst cycle with basic interface");

   cover_burst_c: cover property (state_r == ST_BURST ##2 state_r == ST_BURST);
   cover_gap_c: cover property (state_r == ST_GAP);
   cover_pin_wait_c: cover property (state_r == ST_TW && wcnt_r == 2'h0 && wait_s_r);
   cover_dtc_c: cover property (dtc_ack);
endmodule : external_bus_unit

// File: hw/ext_bus_pkg.sv
// constants, register map and request carrier for the external bus controller
package ext_bus_pkg;
   // register byte offsets on the AHB-Lite slave
   localparam logic [7:0] REG_BUS_CONTROL = 8'h00;
   localparam logic [7:0] REG_SYS_CTRL = 8'h04;
   localparam logic [7:0] REG_WAIT_CFG = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   // reset values
   localparam logic [7:0] BUS_CONTROL_RST = 8'hd3;
   localparam logic [7:0] SYS_CTRL_RST = 8'h00;
   localparam logic [7:0] WAIT_CFG_RST = 8'hf3;
   // bus_control field positions
   localparam int IDLE_INSERT_BIT = 6;
   localparam int BURST_ROM_BIT = 5;
   localparam int BURST_STATE_BIT = 4;
   localparam int BURST_WORD_BIT = 3;
   localparam int IO_RANGE_HI = 1;
   localparam int IO_RANGE_LO = 0;
   // system_control_reg field position
   localparam int IO_STROBE_EN_BIT = 0;
   // wait configuration field positions
   localparam int ACCESS_STATE_BIT = 4;
   localparam int WAIT_MODE_HI = 3;
   localparam int WAIT_MODE_LO = 2;
   localparam int WAIT_CNT_HI = 1;
   localparam int WAIT_CNT_LO = 0;
   localparam logic [1:0] WAIT_MODE_OFF = 2'h1;
   // status register field positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_OWNER_BIT = 1;
   localparam int ST_BURST_BIT = 2;
   localparam int ST_WAIT_BIT = 3;
   // burst word limits
   localparam logic [3:0] BURST_WORDS_SHORT = 4'h4;
   localparam logic [3:0] BURST_WORDS_LONG = 4'h8;
   // io select window: addr[15:10] must match, addr[9:8] equals the range field
   localparam logic [5:0] IO_PAGE_TOP = 6'h3f;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // one internal master's request
   typedef struct packed {
      logic req;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mreq_t;
endpackage : ext_bus_pkg

// File: hw/bus_arbiter.sv
// two-master arbiter for the internal bus, transfer controller first
`timescale 1ns/1ps
module bus_arbiter
   import ext_bus_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // requests and lock
   input wire logic cpu_req,
   input wire logic dtc_req,
   input wire logic lock,
   // grants
   output logic grant_cpu,
   output logic grant_dtc
);
   logic [1:0] gnt_r;
   logic [1:0] gnt_nxt;

   // grant is frozen while locked so a transfer never changes owner midway
   always_comb begin
      gnt_nxt = gnt_r;
      if (!lock) begin
         if (dtc_req) begin
            gnt_nxt = 2'h2;
         end else if (cpu_req) begin
            gnt_nxt = 2'h1;
         end else begin
            gnt_nxt = 2'h0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gnt_r <= 2'h0;
      end else begin
         gnt_r <= gnt_nxt;
      end
   end

   assign grant_cpu = gnt_r[0];
   assign grant_dtc = gnt_r[1];
endmodule : bus_arbiter

// File: sim/ext_mem_model.sv
// behavioural external memory with a programmable wait request
`timescale 1ns/1ps
module ext_mem_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // external bus pins
   input wire logic [15:0] ext_addr,
   input wire logic [7:0] ext_data_out,
   input wire logic ext_data_oe,
   input wire logic addr_strobe_n,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [7:0] ext_data_in,
   output logic wait_n,
   // wait states asked for at the start of each strobe
   input wire logic [3:0] hold_cycles
);
   logic [7:0] mem [256];
   logic [7:0] last_r;
   logic [1:0] keep_r;
   logic [3:0] wait_cnt_r;
   logic rd_q_r;
   logic wr_q_r;
   logic fired_r;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   // unselected lines show the inverse of their last value, never a stale copy
   assign ext_data_in = (!rd_n || !addr_strobe_n || keep_r != 2'h0) ? mem[ext_addr[7:0]] : ~last_r;
   // a slow device asks for waits ahead of the strobe, since the controller sees the pin
   // two cycles late; it lets go hold_cycles after the strobe falls
   assign wait_n = (hold_cycles == 4'h0) || (fired_r && wait_cnt_r == 4'h0);
   // short data hold after the read strobe, wait counter and write capture
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_r <= 8'h00;
         keep_r <= 2'h0;
         wait_cnt_r <= 4'h0;
         rd_q_r <= 1'b1;
         wr_q_r <= 1'b1;
         fired_r <= 1'b0;
      end else begin
         last_r <= ext_data_in;
         keep_r <= !rd_n ? 2'h3 : (keep_r != 2'h0 ? keep_r - 2'h1 : 2'h0);
         rd_q_r <= rd_n;
         wr_q_r <= wr_n;
         if ((rd_q_r && !rd_n) || (wr_q_r && !wr_n)) begin
            wait_cnt_r <= hold_cycles;
            fired_r <= 1'b1;
         end else begin
            if (wait_cnt_r != 4'h0) wait_cnt_r <= wait_cnt_r - 4'h1;
            if (rd_n && wr_n) fired_r <= 1'b0;
         end
         if (!wr_n && ext_data_oe) begin
            mem[ext_addr[7:0]] <= ext_data_out;
         end
      end
   end
endmodule : ext_mem_model

// File: sim/external_bus_unit_tb.sv
// self-checking bench for the external bus controller
`timescale 1ns/1ps
module external_bus_unit_tb;
   import ext_bus_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, wait_n;
   logic cpu_ack, dtc_ack, ext_data_oe, addr_strobe_n, rd_n, wr_n, seen, cur_w;
   logic [31:0] haddr, hwdata, hrdata, r, l0, l1;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] hold;
   logic [7:0] rdata, ext_data_out, ext_data_in;
   logic [15:0] ext_addr;
   logic [7:0] exp_mem [256];
   logic [31:0] lat [6];
   logic [31:0] keep [4][6];
   logic [7:0] bc_t [4] = '{8'ha3, 8'hb3, 8'hab, 8'h83};
   logic [7:0] wc_t [4] = '{8'h03, 8'h03, 8'h13, 8'h03};
   logic [8:0] q_cpu [$];
   logic [8:0] q_dtc [$];
   logic [8:0] e;
   mreq_t cpu_in, dtc_in;
   int num_errors, n_tests;
   assign hready = hreadyout;
   external_bus_unit i_external_bus_unit (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hready, .hwdata, .hreadyout, .hresp, .hrdata, .cpu_in, .dtc_in, .cpu_ack,
      .dtc_ack, .rdata, .ext_addr, .ext_data_out, .ext_data_oe, .ext_data_in,
      .addr_strobe_n, .rd_n, .wr_n, .wait_n);
   ext_mem_model i_ext_mem_model (.hclk, .hresetn, .ext_addr, .ext_data_out, .ext_data_oe,
      .addr_strobe_n, .rd_n, .wr_n, .ext_data_in, .wait_n, .hold_cycles(hold));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task close_out();
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
      n_tests++;
      if (s !== x) begin
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
         num_errors++;
      end
   endtask : chk
   // one single word transfer; the address phase holds until hready is seen high
   task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask : ahb
   // c[0]: fields change at the previous ack edge, c[1]: request stays up after ack
   task automatic mst(input bit d, input bit w, input logic [15:0] a, input logic [1:0] c,
                      output logic [31:0] n);
      logic [7:0] v;
      mreq_t m;
      v = 8'($urandom);
      m = '{req: 1'b1, write: w, addr: a, wdata: v};
      n = 0;
      if (!c[0]) @(posedge hclk);
      seen = 1'b0;
      cur_w = w;
      if (d) begin
         dtc_in <= m;
         q_dtc.push_back({!w, exp_mem[a[7:0]]});
      end else begin
         cpu_in <= m;
         q_cpu.push_back({!w, exp_mem[a[7:0]]});
      end
      if (w) exp_mem[a[7:0]] = v;
      do begin
         @(posedge hclk);
         n = n + 1;
      end while ((d ? dtc_ack : cpu_ack) !== 1'b1);
      if (!c[1]) begin
         if (d) dtc_in <= '0;
         else cpu_in <= '0;
      end
   endtask : mst
   // watcher: strobes, ownership and read data against the oldest note
   always @(posedge hclk) begin
      if (addr_strobe_n === 1'b0) seen <= 1'b1;
      if (wr_n === 1'b0) chk("data oe", 1, 32'(ext_data_oe));
      if (rd_n === 1'b0) chk("read in write", 0, 32'(cur_w));
      if (cpu_ack === 1'b1) chk("one owner", 0, 32'(dtc_ack));
      if (cpu_ack === 1'b1 && q_cpu.size() > 0) begin
         e = q_cpu.pop_front();
         if (e[8]) chk("cpu rdata", 32'(e[7:0]), 32'(rdata));
      end
      if (dtc_ack === 1'b1 && q_dtc.size() > 0) begin
         e = q_dtc.pop_front();
         if (e[8]) chk("dtc rdata", 32'(e[7:0]), 32'(rdata));
      end
   end
   // a hang counts as a mismatch
   initial begin
      #200000;
      num_errors++;
      close_out();
   end
   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, hold, seen, cur_w} = '0;
      cpu_in = '0;
      dtc_in = '0;
      num_errors = 0;
      n_tests = 0;
      for (int i = 0; i < 256; i++) exp_mem[i] = 8'(i) ^ 8'h5a;
      void'($urandom(32'h55c9f802));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, then an unmapped place
      ahb(0, REG_BUS_CONTROL, 0, r);
      chk("bus_control", 32'(BUS_CONTROL_RST), r);
      ahb(0, REG_SYS_CTRL, 0, r);
      chk("system_control_reg", 32'(SYS_CTRL_RST), r);
      ahb(0, REG_WAIT_CFG, 0, r);
      chk("wait cfg", 32'(WAIT_CFG_RST), r);
      ahb(0, 8'h10, 0, r);
      chk("unmapped", 0, r);
      // random setup with reserved bits left at their reset levels
      l0 = ($urandom & 32'h7b) | 32'h80;
      ahb(1, REG_BUS_CONTROL, l0, r);
      ahb(0, REG_BUS_CONTROL, 0, r);
      chk("bus_control rw", l0, r);
      // two-state: fixed length even with the wait pin pulled low
      ahb(1, REG_BUS_CONTROL, 32'hd3, r);
      ahb(1, REG_WAIT_CFG, 32'h03, r);
      hold = 4'h6;
      mst(0, 1, 16'h0010, 2'b00, l0);
      chk("2st write", 5, l0);
      mst(0, 0, 16'h0010, 2'b00, l0);
      chk("2st read", 5, l0);
      hold = 4'h0;
      // three-state with every program wait count
      for (int w = 0; w < 4; w++) begin
         ahb(1, REG_WAIT_CFG, 32'h10 | w, r);
         mst(1, w[0], 16'h0030 + 16'(w), 2'b00, l0);
         chk("3st wait", 32'(6 + w), l0);
      end
      // pin wait mode: the wait request stretches only when asked
      ahb(1, REG_WAIT_CFG, 32'h18, r);
      hold = 4'h6;
      mst(0, 0, 16'h0040, 2'b00, l1);
      hold = 4'h0;
      mst(0, 0, 16'h0042, 2'b00, l0);
      chk("pin wait", 1, 32'(l1 > l0));
      // write straight after a read, idle insertion on then off
      ahb(1, REG_WAIT_CFG, 32'h03, r);
      for (int k = 0; k < 2; k++) begin
         ahb(1, REG_BUS_CONTROL, k ? 32'h93 : 32'hd3, r);
         mst(0, 0, 16'h0050, 2'b10, l0);
         mst(0, 1, 16'h0051, 2'b01, lat[k]);
      end
      chk("idle gap", 1, lat[0] - lat[1]);
      // six sequential reads under each burst setup and the basic interface
      for (int k = 0; k < 4; k++) begin
         ahb(1, REG_BUS_CONTROL, 32'(bc_t[k]), r);
         ahb(1, REG_WAIT_CFG, 32'(wc_t[k]), r);
         for (int i = 0; i < 6; i++) mst(0, 0, 16'h0060 + 16'(i), {i < 5, i > 0}, keep[k][i]);
      end
      chk("burst 2 states", 1, keep[1][1] - keep[0][1]);
      chk("burst vs width", keep[0][1], keep[2][1]);
      chk("4 word limit", 1, 32'(keep[0][4] > keep[0][1]));
      chk("8 word limit", keep[2][1], keep[2][4]);
      chk("basic select", 1, 32'(keep[3][1] > keep[0][1]));
      // address strobe on every access, then io select only inside its window
      ahb(1, REG_BUS_CONTROL, 32'hd3, r);
      mst(0, 0, 16'h0070, 2'b00, l0);
      chk("addr strobe", 1, 32'(seen));
      ahb(1, REG_SYS_CTRL, 32'h01, r);
      for (int j = 0; j < 8; j++) begin
         ahb(1, REG_BUS_CONTROL, 32'hd0 | (j / 2), r);
         mst(0, 0, {6'h3f, 2'(j / 2 + j % 2), 8'h00}, 2'b00, l0);
         chk("io select", 32'(j % 2 == 0), 32'(seen));
      end
      ahb(1, REG_SYS_CTRL, 32'h00, r);
      // both masters at once: the transfer controller wins, the cpu waits
      fork
         mst(0, 0, 16'h0080, 2'b00, l0);
         mst(1, 0, 16'h0081, 2'b00, l1);
      join
      chk("dtc first", 1, 32'(l1 < l0));
      chk("dtc length", 5, l1);
      close_out();
   end
endmodule : external_bus_unit_tb
